// ==== cw_upper_pkg.sv ====
// constants for the fieldbus command word upper-bit decoder
package cw_upper_pkg;
    localparam int          CW_WIDTH      = 16;
    localparam int          REF_WIDTH     = 16;
    localparam int          BIT_FAULT_RST = 7;
    localparam int          BIT_JOG1      = 8;
    localparam int          BIT_JOG2      = 9;
    localparam int          BIT_REMOTE    = 10;
    localparam int          BIT_LOC_SEL   = 11;
    localparam int          BIT_USER_LO   = 12;
    localparam int          BIT_USER_HI   = 15;
    localparam int          USER_WIDTH    = BIT_USER_HI - BIT_USER_LO + 1;
    localparam logic [15:0] CW_RESET      = 16'h0000;
    localparam logic [15:0] REF_RESET     = 16'h0000;
    // external control locations
    typedef enum logic {
        first_outside_location,
        second_outside_location
    } location_t;
endpackage

// ==== fieldbus_control_word_upper_decode.sv ====
// decoder for bits 7 to 15 of the fieldbus command word
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
module fieldbus_control_word_upper_decode
    import cw_upper_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // fieldbus write of command word and reference
    input  wire logic                  cw_write_i,
    input  wire logic [CW_WIDTH-1:0]   cw_data_i,
    input  wire logic [REF_WIDTH-1:0]  ref_data_i,
    // configuration: fieldbus as source
    input  wire logic                  fb_src_fault_rst_i,
    input  wire logic                  fb_src_jog_i,
    input  wire logic                  fb_src_location_i,
    // decoded outputs
    output logic [CW_WIDTH-1:0]        fieldbus_command_word_o,
    output logic [REF_WIDTH-1:0]       reference_o,
    output logic                       fault_reset_pulse_o,
    output logic                       goto_power_on_blocked_o,
    output logic                       jog1_req_o,
    output logic                       jog2_req_o,
    output logic                       fieldbus_ctrl_en_o,
    output logic                       ramps_locked_o,
    output logic                       location_select_bit_o,
    output logic [USER_WIDTH-1:0]      user_bits_o
);

    // ****************************************************************
    // accepted word
    // ****************************************************************
    logic [CW_WIDTH-1:0]  cw_ff;
    logic [REF_WIDTH-1:0] ref_ff;
    logic                 ctrl_en_ff;
    logic                 lock_ff;
    logic                 rst_prev_ff;
    logic                 pulse_ff;
    logic                 jog1_ff;
    logic                 jog2_ff;
    logic                 loc_ff;
    logic                 remote_w;
    logic                 all_zero_w;
    logic                 accept_w;

    assign remote_w   = cw_data_i[BIT_REMOTE];
    assign all_zero_w = (cw_data_i == CW_RESET) && (ref_data_i == REF_RESET);
    // retain last word when remote bit clear and anything nonzero
    assign accept_w   = cw_write_i && (remote_w || all_zero_w);

    // a sourced bit only counts while the fieldbus owns that signal
    function automatic logic fb_gate(input logic src, input logic bit_val);
        return src && bit_val;
    endfunction

    // store incoming word in internal form
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cw_ff  <= CW_RESET;
            ref_ff <= REF_RESET;
        end else if (accept_w) begin
            cw_ff  <= cw_data_i;
            ref_ff <= ref_data_i;
        end
    end

    // enable and ramp lock state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_en_ff <= 1'b0;
            lock_ff    <= 1'b0;
        end else if (cw_write_i) begin
            if (remote_w) begin
                ctrl_en_ff <= 1'b1;
                lock_ff    <= 1'b0;
            end else if (all_zero_w) begin
                ctrl_en_ff <= 1'b1;
                lock_ff    <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // fault reset edge detect
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_prev_ff <= 1'b0;
            pulse_ff    <= 1'b0;
        end else begin
            rst_prev_ff <= cw_ff[BIT_FAULT_RST];
            pulse_ff    <= fb_gate(fb_src_fault_rst_i,
                                   cw_ff[BIT_FAULT_RST] && !rst_prev_ff);
        end
    end

    // ****************************************************************
    // jog requests and location
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            jog1_ff <= 1'b0;
            jog2_ff <= 1'b0;
        end else begin
            jog1_ff <= fb_gate(fb_src_jog_i, cw_ff[BIT_JOG1]);
            jog2_ff <= fb_gate(fb_src_jog_i, cw_ff[BIT_JOG2]);
        end
    end

    // location only follows word while fieldbus selects it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loc_ff <= first_outside_location;
        end else if (fb_src_location_i) begin
            loc_ff <= cw_ff[BIT_LOC_SEL];
        end
    end

    // outputs
    assign fieldbus_command_word_o = cw_ff;
    assign reference_o             = ref_ff;
    assign fault_reset_pulse_o     = pulse_ff;
    assign goto_power_on_blocked_o = pulse_ff;
    assign jog1_req_o              = jog1_ff;
    assign jog2_req_o              = jog2_ff;
    assign fieldbus_ctrl_en_o      = ctrl_en_ff;
    assign ramps_locked_o          = lock_ff;
    assign location_select_bit_o   = loc_ff;
    assign user_bits_o             = cw_ff[BIT_USER_HI:BIT_USER_LO];

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_rise;
        fb_src_fault_rst_i && cw_ff[BIT_FAULT_RST] && !rst_prev_ff;
    endsequence
    property p_rise_pulse;
        @(posedge clk_i) disable iff (!rst_n_i) s_rise |=> fault_reset_pulse_o;
    endproperty
    a_rise_pulse: assert property (p_rise_pulse) else $error("missed fault reset");
    property p_pulse_single;
        @(posedge clk_i) disable iff (!rst_n_i) fault_reset_pulse_o |=> !fault_reset_pulse_o;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("pulse too long");
    property p_src_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
            !fb_src_jog_i |=> !jog1_req_o && !jog2_req_o;
    endproperty
    a_src_gate: assert property (p_src_gate) else $error("jog not gated");
    property p_jog1;
        @(posedge clk_i) disable iff (!rst_n_i)
            fb_src_jog_i && cw_ff[BIT_JOG1] |=> jog1_req_o;
    endproperty
    a_jog1: assert property (p_jog1) else $error("jog1 lost");
    property p_jog2;
        @(posedge clk_i) disable iff (!rst_n_i)
            fb_src_jog_i && cw_ff[BIT_JOG2] |=> jog2_req_o;
    endproperty
    a_jog2: assert property (p_jog2) else $error("jog2 lost");
    property p_retain;
        @(posedge clk_i) disable iff (!rst_n_i)
            cw_write_i && !remote_w && !all_zero_w |=> $stable(fieldbus_command_word_o);
    endproperty
    a_retain: assert property (p_retain) else $error("word not retained");
    property p_lock;
        @(posedge clk_i) disable iff (!rst_n_i)
            cw_write_i && all_zero_w |=> ramps_locked_o && fieldbus_ctrl_en_o;
    endproperty
    a_lock: assert property (p_lock) else $error("ramps not locked");
    property p_loc;
        @(posedge clk_i) disable iff (!rst_n_i)
            !fb_src_location_i |=> $stable(location_select_bit_o);
    endproperty
    a_loc: assert property (p_loc) else $error("location moved");
    property p_user;
        @(posedge clk_i) disable iff (!rst_n_i)
            accept_w |=> user_bits_o == $past(cw_data_i[BIT_USER_HI:BIT_USER_LO]);
    endproperty
    a_user: assert property (p_user) else $error("user bits wrong");
    // a remote write always enables and releases the ramp lock
    property p_remote_en;
        @(posedge clk_i) disable iff (!rst_n_i)
            cw_write_i && remote_w |=> fieldbus_ctrl_en_o && !ramps_locked_o;
    endproperty
    a_remote_en: assert property (p_remote_en) else $error("remote not enabled");
    // an accepted write lands whole in the stored word and reference
    property p_accept;
        @(posedge clk_i) disable iff (!rst_n_i)
            accept_w |=> fieldbus_command_word_o == $past(cw_data_i)
                         && reference_o == $past(ref_data_i);
    endproperty
    a_accept: assert property (p_accept) else $error("accepted word lost");
    // no pulse unless the stored bit has just risen
    property p_no_spurious;
        @(posedge clk_i) disable iff (!rst_n_i)
            !(fb_src_fault_rst_i && cw_ff[BIT_FAULT_RST] && !rst_prev_ff)
                |=> !fault_reset_pulse_o;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("spurious fault reset");
    // a write that raises the stored bit 7, seen from the bus side
    sequence s_fault_write;
        accept_w && cw_data_i[BIT_FAULT_RST] && !cw_ff[BIT_FAULT_RST];
    endsequence
    property p_fault_write;
        @(posedge clk_i) disable iff (!rst_n_i)
            s_fault_write ##1 fb_src_fault_rst_i
                |=> fault_reset_pulse_o && goto_power_on_blocked_o;
    endproperty
    a_fault_write: assert property (p_fault_write) else $error("write gave no reset");
    // location follows the stored bit one edge later while selected
    property p_loc_follow;
        @(posedge clk_i) disable iff (!rst_n_i)
            fb_src_location_i |=> location_select_bit_o == $past(cw_ff[BIT_LOC_SEL]);
    endproperty
    a_loc_follow: assert property (p_loc_follow) else $error("location not followed");
    // cleared jog bits drop both requests
    property p_jog_off;
        @(posedge clk_i) disable iff (!rst_n_i)
            !cw_ff[BIT_JOG1] && !cw_ff[BIT_JOG2] |=> !jog1_req_o && !jog2_req_o;
    endproperty
    a_jog_off: assert property (p_jog_off) else $error("jog request stuck");

endmodule // fieldbus_control_word_upper_decode

// ==== fb_master.sv ====
// fieldbus master model that writes the command word and reference
`timescale 1ns/1ps
module fb_master (
    // clock
    input  wire logic        clk_i,
    // write toward the decoder
    output logic             cw_write_o,
    output logic [15:0]      cw_data_o,
    output logic [15:0]      ref_data_o
);
    // lines start quiet
    initial begin
        cw_write_o <= 1'b0;
        cw_data_o  <= 16'h0000;
        ref_data_o <= 16'h0000;
    end
    // one write cycle; released lines show the inverse so stale data never looks valid
    task automatic send(input logic [15:0] w, input logic [15:0] r);
        @(posedge clk_i);
        cw_write_o <= 1'b1;
        cw_data_o  <= w;
        ref_data_o <= r;
        @(posedge clk_i);
        cw_write_o <= 1'b0;
        cw_data_o  <= ~w;
        ref_data_o <= ~r;
    endtask
endmodule // fb_master

// ==== tb_fieldbus_control_word_upper_decode.sv ====
// self-checking bench for the command word upper-bit decoder
`timescale 1ns/1ps
module tb_fieldbus_control_word_upper_decode;
    import cw_upper_pkg::*;
    logic                  clk_i, rst_n_i, cw_write_i, src_f, src_j, src_l;
    logic [15:0]           cw_data_i, ref_data_i, word_o, ref_o;
    logic                  pulse, blocked, jog1, jog2, en, lock, loc;
    logic [USER_WIDTH-1:0] user;
    int                    bad_count = 0;
    int                    tests_run = 0;
    // packed view: en 400 lock 200 loc 100 jog1 80 jog2 40 pulse 20 blocked 10 user 0f
    wire  [15:0]           flags = {5'h00, en, lock, loc, jog1, jog2, pulse, blocked, user};
    fb_master master (.clk_i(clk_i), .cw_write_o(cw_write_i), .cw_data_o(cw_data_i),
                      .ref_data_o(ref_data_i));
    fieldbus_control_word_upper_decode DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .cw_write_i(cw_write_i), .cw_data_i(cw_data_i), .ref_data_i(ref_data_i),
        .fb_src_fault_rst_i(src_f), .fb_src_jog_i(src_j), .fb_src_location_i(src_l),
        .fieldbus_command_word_o(word_o), .reference_o(ref_o),
        .fault_reset_pulse_o(pulse), .goto_power_on_blocked_o(blocked),
        .jog1_req_o(jog1), .jog2_req_o(jog2), .fieldbus_ctrl_en_o(en),
        .ramps_locked_o(lock), .location_select_bit_o(loc), .user_bits_o(user));
    // 200 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // verdict and end of run
    task automatic close_out();
        if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // compare one value
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one write, then look just after the accepting edge
    task automatic wr(input logic [15:0] w, input logic [15:0] r);
        master.send(w, r);
        #1;
    endtask
    // move to just after the next edge
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask
    // fault reset edge, pulse width, enable
    task automatic sc_fault();
        wr(16'h0480, 16'h0000);
        chk(word_o, 16'h0480);
        chk(flags, 16'h0400);
        step();
        chk(flags, 16'h0430);
        step();
        chk(flags, 16'h0400);
    endtask
    // both jog requests, then source switched away
    task automatic sc_jog();
        wr(16'h0700, 16'h0000);
        step();
        chk(flags, 16'h04c0);
        wr(16'h0500, 16'h0000);
        step();
        chk(flags, 16'h0480);
        wr(16'h0600, 16'h0000);
        step();
        chk(flags, 16'h0440);
        wr(16'h0400, 16'h0000);
        @(posedge clk_i);
        src_f <= 1'b0;
        src_j <= 1'b0;
        wr(16'h0780, 16'h0000);
        step();
        chk(flags, 16'h0400);
    endtask
    // refused write, all-zero write, location and user bits
    task automatic sc_remote();
        wr(16'h1234, 16'h0001);
        step();
        chk(word_o, 16'h0780);
        chk(ref_o, 16'h0000);
        wr(16'h0000, 16'h0000);
        chk(flags, 16'h0600);
        @(posedge clk_i);
        src_l <= 1'b1;
        wr(16'hac00, 16'h0000);
        step();
        chk(flags, 16'h050a);
        @(posedge clk_i);
        src_l <= 1'b0;
        wr(16'h0400, 16'h0055);
        step();
        chk(flags, 16'h0500);
        chk(ref_o, 16'h0055);
    endtask
    // mid-run reset clears every output, then no false edge on release
    task automatic sc_reset();
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        step();
        chk(word_o, 16'h0000);
        chk(ref_o, 16'h0000);
        chk(flags, 16'h0000);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        step();
        step();
        chk(flags, 16'h0000);
    endtask
    // watchdog
    initial begin
        #100000;
        bad_count++;
        close_out();
    end
    // main sequence
    initial begin
        rst_n_i <= 1'b0;
        src_f   <= 1'b1;
        src_j   <= 1'b1;
        src_l   <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        step();
        chk(word_o, 16'h0000);
        chk(flags, 16'h0000);
        sc_fault();
        sc_jog();
        sc_remote();
        sc_reset();
        close_out();
    end
endmodule // tb_fieldbus_control_word_upper_decode
